// ---- pkg/ocp_cfg.svh ----
// Constants for the overcurrent PWM kill latch
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// Positions within the synchroniser bus
`define OCP_SYNC_CMP_BIT 0
`define OCP_SYNC_REL_BIT 1
`define OCP_SYNC_WIDTH 2
// Comparator idle low, release switch idle high (active low)
`define OCP_SYNC_RESET 2'h2

// Trip counter
`define OCP_TRIP_CNT_RESET 8'h00
`define OCP_TRIP_CNT_MAX 8'hFF
`define OCP_TRIP_CNT_INC 8'h01

// Output pin and release edge history after reset
`define OCP_PIN_RESET 1'h0
`define OCP_REL_PREV_RESET 1'h1

`endif

// ---- pkg/ocp_pkg.sv ----
// Types shared by the overcurrent PWM kill latch files
package ocp_pkg;

    typedef enum logic {
        OCP_RELEASED,
        OCP_STOPPED
    } ocp_latch_e;

    typedef struct packed {
        logic latchReleased;
        logic overcurrent;
        logic tripPulse;
        logic releaseAccepted;
        logic releaseRefused;
        logic [7:0] tripCount;
    } ocp_status_s;

endpackage : ocp_pkg

// ---- design/ocp_sync.sv ----
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none

module ocp_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_syncOut;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Only the second stage reads the first
            always_comb begin
                next_stage1[i] = sys_rst ? RESET_VAL[i] : asyncIn[i];
                next_syncOut[i] = sys_rst ? RESET_VAL[i] : stage1[i];
            end

            always_ff @(posedge mclk) begin
                stage1[i] <= next_stage1[i];
                syncOut[i] <= next_syncOut[i];
            end
        end
    endgenerate

endmodule : ocp_sync

`default_nettype wire

// ---- design/ocp_kill_latch.sv ----
// Overcurrent protection gate between timer PWM and the protected pin
`timescale 1ns/10ps
`default_nettype none
`include "ocp_cfg.svh"

module ocp_kill_latch (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic timerPwmOut,
    input wire logic gateEnable,
    input wire logic overcurrentComparatorOut,
    input wire logic releaseSwitchN,
    output logic protectedPwmPin,
    output ocp_pkg::ocp_status_s status
);
    import ocp_pkg::*;

    // Synchroniser bus, one bit per asynchronous input
    logic [`OCP_SYNC_WIDTH-1:0] rawIn;
    logic [`OCP_SYNC_WIDTH-1:0] syncIn;
    logic cmpHigh;
    logic relLevelN;

    // Release edge history
    logic relPrevN;
    logic next_relPrevN;
    logic relPulse;

    // Protection latch and gated output
    ocp_latch_e latchState;
    ocp_latch_e next_latchState;
    logic next_protectedPwmPin;

    // One-cycle event pulses and the trip count
    logic tripPulse;
    logic next_tripPulse;
    logic relAccepted;
    logic next_relAccepted;
    logic relRefused;
    logic next_relRefused;
    logic [7:0] tripCount;
    logic [7:0] next_tripCount;

    // Latch state decoded by the gate, the events and the status
    function automatic logic is_released(input ocp_latch_e state);
        return state == OCP_RELEASED;
    endfunction : is_released

    // Press of the active-low switch: idle before, pressed now
    function automatic logic press_seen(
        input logic prevN,
        input logic nowN
    );
        return prevN && !nowN;
    endfunction : press_seen

    // Trip only from released; a comparator still high while stopped adds nothing
    function automatic logic trip_request(
        input ocp_latch_e state,
        input logic cmp
    );
        return is_released(state) && cmp;
    endfunction : trip_request

    function automatic logic release_request(
        input ocp_latch_e state,
        input logic pulse
    );
        return !is_released(state) && pulse;
    endfunction : release_request

    // Pin level for the latch state that the next edge will hold
    function automatic logic gate_level(
        input logic pwm,
        input logic enable,
        input ocp_latch_e state
    );
        return pwm && enable && is_released(state);
    endfunction : gate_level

    // Saturates so a burst of faults cannot wrap the count back to zero
    function automatic logic [7:0] count_step(
        input logic [7:0] count,
        input logic hit
    );
        logic [7:0] result;
        result = count;
        if (hit && count != `OCP_TRIP_CNT_MAX) begin
            result = count + `OCP_TRIP_CNT_INC;
        end
        return result;
    endfunction : count_step

    assign rawIn[`OCP_SYNC_CMP_BIT] = overcurrentComparatorOut;
    assign rawIn[`OCP_SYNC_REL_BIT] = releaseSwitchN;

    // Both inputs are asynchronous to mclk
    ocp_sync #(
        .WIDTH(`OCP_SYNC_WIDTH),
        .RESET_VAL(`OCP_SYNC_RESET)
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn(rawIn),
        .syncOut(syncIn)
    );

    // Comparator level as seen by the latch
    assign cmpHigh = syncIn[`OCP_SYNC_CMP_BIT];
    assign relLevelN = syncIn[`OCP_SYNC_REL_BIT];

    // Press edge of the active-low switch; holding it gives one pulse only
    assign relPulse = press_seen(relPrevN, relLevelN);

    // History resets to the idle level so leaving reset shows no false press
    always_comb begin
        next_relPrevN = relLevelN;
        if (sys_rst) begin
            next_relPrevN = `OCP_REL_PREV_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        relPrevN <= next_relPrevN;
    end

    // Latch: trip has priority over release in the same cycle
    always_comb begin
        next_latchState = latchState;
        unique case (latchState)
            OCP_RELEASED: begin
                if (trip_request(latchState, cmpHigh)) begin
                    next_latchState = OCP_STOPPED;
                end
            end
            OCP_STOPPED: begin
                // Falling comparator alone never reopens the gate
                if (release_request(latchState, relPulse) && !cmpHigh) begin
                    next_latchState = OCP_RELEASED;
                end
            end
        endcase
        // Reset opens the gate; a fault present then trips it three edges later
        if (sys_rst) begin
            next_latchState = OCP_RELEASED;
        end
    end

    always_ff @(posedge mclk) begin
        latchState <= next_latchState;
    end

    // A refused press is dropped, not queued, so a lasting fault needs a new press
    always_comb begin
        next_tripPulse = trip_request(latchState, cmpHigh);
        next_relAccepted = release_request(latchState, relPulse) && !cmpHigh;
        next_relRefused = release_request(latchState, relPulse) && cmpHigh;
        if (sys_rst) begin
            next_tripPulse = 1'b0;
            next_relAccepted = 1'b0;
            next_relRefused = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        tripPulse <= next_tripPulse;
        relAccepted <= next_relAccepted;
        relRefused <= next_relRefused;
    end

    // Gate uses the next latch state so a trip cuts the pin with no extra cycle
    // Trip latency is still three edges: the price of synchronising the comparator
    always_comb begin
        next_protectedPwmPin = `OCP_PIN_RESET;
        if (!sys_rst) begin
            next_protectedPwmPin = gate_level(timerPwmOut, gateEnable,
                next_latchState);
        end
    end

    always_ff @(posedge mclk) begin
        protectedPwmPin <= next_protectedPwmPin;
    end

    // Kept for diagnosis only
    always_comb begin
        next_tripCount = count_step(tripCount, next_tripPulse);
        if (sys_rst) begin
            next_tripCount = `OCP_TRIP_CNT_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        tripCount <= next_tripCount;
    end

    // Every status field comes straight from a register
    always_comb begin
        status.latchReleased = is_released(latchState);
        status.overcurrent = cmpHigh;
        status.tripPulse = tripPulse;
        status.releaseAccepted = relAccepted;
        status.releaseRefused = relRefused;
        status.tripCount = tripCount;
    end

endmodule : ocp_kill_latch

`default_nettype wire

// ---- bench/ocp_kill_latch_monitor.sv ----
// Port checker for the kill latch
`timescale 1ns/10ps
`default_nettype none
module ocp_kill_latch_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic timerPwmOut,
    input wire logic gateEnable,
    input wire logic overcurrentComparatorOut,
    input wire logic releaseSwitchN,
    input wire logic protectedPwmPin,
    input wire ocp_pkg::ocp_status_s status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence tripCause;
        status.overcurrent && status.latchReleased;
    endsequence
    sequence pressEdge;
        $past(releaseSwitchN, 4) && !$past(releaseSwitchN, 3);
    endsequence
    pin_follow_a: assert property (1 |=> protectedPwmPin ==
        ($past(timerPwmOut & gateEnable) & status.latchReleased)) else $error("pin");
    trip_stop_a: assert property (tripCause |=> !status.latchReleased && status.tripPulse)
        else $error("no trip");
    hold_stop_a: assert property (!status.latchReleased |=>
        !status.latchReleased || status.releaseAccepted) else $error("stop lost");
    accept_quiet_a: assert property (status.releaseAccepted |->
        status.latchReleased && !$past(status.overcurrent)) else $error("bad accept");
    refuse_high_a: assert property (status.releaseRefused |->
        !status.latchReleased && $past(status.overcurrent)) else $error("bad refuse");
    press_sync_a: assert property (status.releaseAccepted || status.releaseRefused |->
        $past(sys_rst, 4) or pressEdge) else $error("press timing");
    cmp_sync_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
        status.overcurrent == $past(overcurrentComparatorOut, 2)) else $error("sync");
    trip_count_a: assert property (status.tripPulse |->
        (status.tripCount == $past(status.tripCount) + 8'h01 || &status.tripCount)
        ##1 !status.tripPulse) else $error("count");
endmodule : ocp_kill_latch_monitor
bind ocp_kill_latch ocp_kill_latch_monitor ocp_kill_latch_monitor_i (.mclk, .sys_rst,
    .timerPwmOut, .gateEnable, .overcurrentComparatorOut, .releaseSwitchN,
    .protectedPwmPin, .status);
`default_nettype wire

// ---- bench/ocp_partner.sv ----
// PWM timer and current comparator model
`timescale 1ns/10ps
`default_nettype none
module ocp_partner (
    input wire logic mclk,
    input wire logic dutyHigh,
    input wire logic cmpHold,
    input wire logic pinLevel,
    output logic timerPwmOut,
    output logic overcurrentComparatorOut
);
    logic [3:0] phase = 4'h0;
    logic [2:0] onRun = 3'h0;
    always @(posedge mclk) begin
        phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
        onRun <= pinLevel ? onRun + {2'h0, onRun != 3'h7} : 3'h0;
    end
    // Half or tenth of a ten-cycle period
    assign timerPwmOut = phase < (dutyHigh ? 4'h5 : 4'h1);
    // A long on-time or cmpHold trips; without cmpHold, current dies with the pin
    assign overcurrentComparatorOut = cmpHold || onRun >= 3'h3;
endmodule : ocp_partner
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the kill latch
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic mclk, sys_rst, gateEnable, releaseSwitchN, dutyHigh, cmpHold;
    logic timerPwmOut, cmpOut, protectedPwmPin;
    ocp_pkg::ocp_status_s status;
    logic [2:0] expQ[$];
    int err_total = 0, checks = 0, cycles = 0;
    ocp_partner ocp_partner_i (.mclk, .dutyHigh, .cmpHold, .pinLevel(protectedPwmPin),
        .timerPwmOut, .overcurrentComparatorOut(cmpOut));
    ocp_kill_latch ocp_kill_latch_i (.mclk, .sys_rst, .timerPwmOut, .gateEnable,
        .overcurrentComparatorOut(cmpOut), .releaseSwitchN, .protectedPwmPin, .status);
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    task automatic cmp_val(input logic [7:0] expV, input logic [7:0] gotV);
        checks++;
        if (gotV !== expV) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, gotV, expV);
        end
    endtask : cmp_val
    task automatic test_done;
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    // Press held long so the release is seen once
    task automatic press;
        releaseSwitchN <= 1'h0;
        repeat (6) @(posedge mclk);
        releaseSwitchN <= 1'h1;
        repeat (6) @(posedge mclk);
    endtask : press
    // Events: trip 4, accept 2, refuse 1
    always @(negedge mclk) begin
        cycles++;
        if (cycles > 2000) begin
            err_total++;
            test_done();
        end else if ({status.tripPulse, status.releaseAccepted, status.releaseRefused} !== 3'h0)
            cmp_val({5'h0, expQ.size() > 0 ? expQ.pop_front() : 3'h0},
                {5'h0, status.tripPulse, status.releaseAccepted, status.releaseRefused});
    end
    initial begin
        void'($urandom(32'hDEDA));
        sys_rst = 1'h1;
        gateEnable = 1'h0;
        releaseSwitchN = 1'h1;
        dutyHigh = 1'h0;
        cmpHold = 1'h0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'h0;
        repeat (40) begin
            @(posedge mclk);
            gateEnable <= 1'($urandom);
        end
        @(posedge mclk);
        gateEnable <= 1'h1;
        press();
        dutyHigh <= 1'h1;
        expQ.push_back(3'h4);
        repeat (30) @(posedge mclk);
        expQ.push_back(3'h2);
        expQ.push_back(3'h4);
        press();
        repeat (20) @(posedge mclk);
        cmpHold <= 1'h1;
        expQ.push_back(3'h1);
        press();
        cmpHold <= 1'h0;
        dutyHigh <= 1'h0;
        repeat (10) @(posedge mclk);
        expQ.push_back(3'h2);
        press();
        repeat (60) @(posedge mclk);
        @(negedge mclk);
        cmp_val(8'h02, status.tripCount);
        cmp_val(8'h00, 8'(expQ.size()));
        test_done();
    end
endmodule : tb_top
`default_nettype wire
